// ---- pkg/ucd_pkg.sv ----
// Constants and carrier types for the serial ports 3/4 config decode block
// How it works
// - Each of the three registers is reached only in config state with its index in the select register.
// - The port-4 shadow is read-only and mirrors the last write to the port-4 FIFO control register.
// - FIFO control bit 0 enables both transmitter and receiver FIFOs.
// - Bit 1 flushes the receiver FIFO and clears itself.
// - Bit 2 flushes the transmitter FIFO and clears itself.
// - Bit 3, the DMA mode select, is stored but changes nothing.
// - Shadow bits 4 and 5 always read zero.
// - Bits 7:6 pick the receiver trigger level of 1, 4, 8 or 14 bytes.
// - Each base register places its port at one of 96 8-byte slots from 100h to 3F8h.
// - Base register bits 7:1 hold I/O address bits 9:3 for the decoder.
// - With address bits 9 and 8 both zero the port is disabled.
// - Base register bit 0 is written as zero by software and always reads zero.
// - A port is selected only when I/O address bits 15:10 are zero.
// - Address bits 2:0 are ignored by the base decode.
// - Both base registers reset to zero so both ports start disabled.
package ucd_pkg;
    localparam logic [7:0] IDX_P4_FIFO_SHADOW = 8'h1a;
    localparam logic [7:0] IDX_P3_BASE = 8'h1b;
    localparam logic [7:0] IDX_P4_BASE = 8'h1c;
    localparam logic [7:0] BASE_RESET = 8'h00;
    localparam logic [7:0] SHADOW_RESET = 8'h00;
    localparam logic [7:0] SHADOW_RD_MASK = 8'hcf;
    localparam logic [2:0] FIFO_CTRL_OFS = 3'h2;
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_FLUSH = 1;
    localparam int FC_TX_FLUSH = 2;
    localparam int FC_DMA = 3;
    localparam int FC_TRIG_LO = 6;
    localparam logic [4:0] TRIG_1 = 5'h01;
    localparam logic [4:0] TRIG_4 = 5'h04;
    localparam logic [4:0] TRIG_8 = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0e;

    // Per-port outputs toward a UART core
    typedef struct packed {
        logic [15:0] base_addr;
        logic enable;
        logic match;
    } ucd_port_s;

    // Decoded FIFO control toward the port-4 core
    typedef struct packed {
        logic fifo_enable;
        logic rx_flush;
        logic tx_flush;
        logic dma_mode;
        logic [4:0] rx_trigger;
    } ucd_fifo_s;
endpackage : ucd_pkg

// ---- design/ucd_port_decode.sv ----
// Base-address decoder for one serial port
`timescale 1ns/100ps
`default_nettype none
module ucd_port_decode (
    input wire logic [7:0] base_select,
    input wire logic [15:0] io_addr,
    output ucd_pkg::ucd_port_s port
);
    // Bits 7:1 carry address bits 9:3; bits 2:0 never take part
    always_comb begin
        port.base_addr = {6'h00, base_select[7:1], 3'h0};
        port.enable = |base_select[7:6];
        port.match = port.enable
            && (io_addr[15:10] == 6'h00)
            && (io_addr[9:3] == base_select[7:1]);
    end
endmodule : ucd_port_decode
`default_nettype wire

// ---- design/ucd_config_regs.sv ----
// Config registers and decode for serial ports 3 and 4
`timescale 1ns/100ps
`default_nettype none
module ucd_config_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic config_state,
    input wire logic [7:0] config_select_index,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_wdata,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    output ucd_pkg::ucd_port_s port3,
    output ucd_pkg::ucd_port_s port4,
    output ucd_pkg::ucd_fifo_s port4_fifo
);
    typedef struct packed {
        logic [7:0] p3_base;
        logic [7:0] p4_base;
        logic [7:0] shadow;
        logic [7:0] rdata;
        logic rvalid;
        ucd_pkg::ucd_port_s p3;
        ucd_pkg::ucd_port_s p4;
        ucd_pkg::ucd_fifo_s fifo;
    } ucd_state_s;

    ucd_state_s st;
    ucd_state_s next_st;
    ucd_pkg::ucd_port_s dec3;
    ucd_pkg::ucd_port_s dec4;
    logic fc_hit;

    ////////////////////////////////////////////////////////////////////
    // Trigger level decode
    function automatic logic [4:0] ucd_trigger(input logic [1:0] code);
        case (code)
            2'b00: ucd_trigger = ucd_pkg::TRIG_1;
            2'b01: ucd_trigger = ucd_pkg::TRIG_4;
            2'b10: ucd_trigger = ucd_pkg::TRIG_8;
            default: ucd_trigger = ucd_pkg::TRIG_14;
        endcase
    endfunction : ucd_trigger

    ////////////////////////////////////////////////////////////////////
    // Address decoders, combinational from the stored bases
    ucd_port_decode u_dec3 (
        .base_select(st.p3_base),
        .io_addr(io_addr),
        .port(dec3)
    );
    ucd_port_decode u_dec4 (
        .base_select(st.p4_base),
        .io_addr(io_addr),
        .port(dec4)
    );

    // Run-time write to FIFO control of port 4 at base plus two
    assign fc_hit = io_wr && dec4.match
        && (io_addr[2:0] == ucd_pkg::FIFO_CTRL_OFS);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        // Flush strobes last one cycle only
        next_st.fifo.rx_flush = 1'b0;
        next_st.fifo.tx_flush = 1'b0;
        // Config writes gated by state and index
        if (config_state && cfg_wr) begin
            case (config_select_index)
                ucd_pkg::IDX_P3_BASE: begin
                    next_st.p3_base = {cfg_wdata[7:1], 1'b0};
                end
                ucd_pkg::IDX_P4_BASE: begin
                    next_st.p4_base = {cfg_wdata[7:1], 1'b0};
                end
                default: begin
                    // Shadow index and others ignore writes
                end
            endcase
        end
        // Shadow keeps the stored bits; flush bits never stay set
        if (fc_hit) begin
            next_st.shadow = io_wdata & ucd_pkg::SHADOW_RD_MASK;
            next_st.shadow[ucd_pkg::FC_RX_FLUSH] = 1'b0;
            next_st.shadow[ucd_pkg::FC_TX_FLUSH] = 1'b0;
            next_st.fifo.fifo_enable = io_wdata[ucd_pkg::FC_ENABLE];
            next_st.fifo.rx_flush = io_wdata[ucd_pkg::FC_RX_FLUSH];
            next_st.fifo.tx_flush = io_wdata[ucd_pkg::FC_TX_FLUSH];
            // Kept for readback only, no core behaviour hangs on it
            next_st.fifo.dma_mode = io_wdata[ucd_pkg::FC_DMA];
            next_st.fifo.rx_trigger =
                ucd_trigger(io_wdata[ucd_pkg::FC_TRIG_LO +: 2]);
        end
        // Config reads; unmatched index reads zero
        if (config_state && cfg_rd) begin
            next_st.rvalid = 1'b1;
            case (config_select_index)
                ucd_pkg::IDX_P4_FIFO_SHADOW:
                    next_st.rdata = st.shadow & ucd_pkg::SHADOW_RD_MASK;
                ucd_pkg::IDX_P3_BASE:
                    next_st.rdata = {st.p3_base[7:1], 1'b0};
                ucd_pkg::IDX_P4_BASE:
                    next_st.rdata = {st.p4_base[7:1], 1'b0};
                default:
                    next_st.rdata = 8'h00;
            endcase
        end
        // Registered decode outputs, one cycle behind io_addr
        next_st.p3 = dec3;
        next_st.p4 = dec4;
    end

    ////////////////////////////////////////////////////////////////////
    // State register; bases reset to zero so ports start disabled
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
            st.p3_base <= ucd_pkg::BASE_RESET;
            st.p4_base <= ucd_pkg::BASE_RESET;
            st.shadow <= ucd_pkg::SHADOW_RESET;
            st.fifo.rx_trigger <= ucd_pkg::TRIG_1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign cfg_rdata = st.rdata;
    assign cfg_rvalid = st.rvalid;
    assign port3 = st.p3;
    assign port4 = st.p4;
    assign port4_fifo = st.fifo;
endmodule : ucd_config_regs
`default_nettype wire

// ---- dv/ucd_config_regs_properties.sv ----
// Assertions for the serial ports 3/4 config decode block
`timescale 1ns/100ps
`default_nettype none
module ucd_config_regs_properties (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic config_state,
    input wire logic cfg_rd,
    input wire logic io_wr,
    input wire logic cfg_rvalid,
    input wire logic [7:0] config_select_index,
    input wire logic [7:0] cfg_rdata,
    input wire logic [15:0] io_addr,
    input wire ucd_pkg::ucd_port_s port3,
    input wire ucd_pkg::ucd_fifo_s port4_fifo
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // A read strobe only counts in config state
    sequence s_rd; config_state && cfg_rd; endsequence
    property p_rv; s_rd |=> cfg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_norv; !(config_state && cfg_rd) |=> !cfg_rvalid; endproperty
    a_norv: assert property (p_norv) else $error("stray valid");
    property p_res; s_rd ##0 config_select_index == 8'h1a
        |=> cfg_rdata[5:4] == 2'h0; endproperty
    a_res: assert property (p_res) else $error("reserved bits set");
    property p_b0; s_rd ##0 config_select_index inside {8'h1b, 8'h1c}
        |=> !cfg_rdata[0]; endproperty
    a_b0: assert property (p_b0) else $error("base bit 0 set");
    // Match is registered, so compare with last cycle's address
    property p_m; port3.match |-> $past(io_addr[15:10]) == 6'h00
        && $past(io_addr[9:3]) == port3.base_addr[9:3]; endproperty
    a_m: assert property (p_m) else $error("bad match");
    property p_en; port3.enable == (port3.base_addr[9:8] != 2'h0); endproperty
    a_en: assert property (p_en) else $error("bad enable");
    property p_fl; port4_fifo.rx_flush || port4_fifo.tx_flush
        |-> $past(io_wr); endproperty
    a_fl: assert property (p_fl) else $error("flush w/o write");
    property p_tr; port4_fifo.rx_trigger inside
        {5'h01, 5'h04, 5'h08, 5'h0e}; endproperty
    a_tr: assert property (p_tr) else $error("bad trigger");
endmodule : ucd_config_regs_properties
bind ucd_config_regs ucd_config_regs_properties u_props (.mclk, .rst_n,
    .config_state, .cfg_rd, .io_wr, .cfg_rvalid, .config_select_index,
    .cfg_rdata, .io_addr, .port3, .port4_fifo);
`default_nettype wire

// ---- dv/ucd_host_model.sv ----
// Host model issuing config and run-time I/O cycles
`timescale 1ns/100ps
`default_nettype none
module ucd_host_model (
    input wire logic mclk,
    output logic config_state,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic io_wr,
    output logic [7:0] config_select_index,
    output logic [7:0] cfg_wdata,
    output logic [7:0] io_wdata,
    output logic [15:0] io_addr,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    initial {config_state, cfg_wr, cfg_rd, io_wr, config_select_index,
        cfg_wdata, io_wdata, io_addr} = '0;
    // Config write; cs low gives a cycle outside config state
    task cw(input logic cs, input logic [7:0] i, input logic [7:0] d);
        @(negedge mclk);
        {config_state, config_select_index} = {cs, i};
        {cfg_wr, cfg_wdata} = {1'b1, d};
        @(negedge mclk);
        cfg_wr = 1'b0;
        cfg_wdata = ~d; // Released data must not linger
    endtask : cw
    // Config read; data and valid taken one cycle after the strobe
    task cr(input logic cs, input logic [7:0] i, output logic [7:0] d,
        output logic v);
        @(negedge mclk);
        {config_state, config_select_index, cfg_rd} = {cs, i, 1'b1};
        @(negedge mclk);
        cfg_rd = 1'b0;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask : cr
    // Run-time I/O cycle, with or without the write strobe
    task iw(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(negedge mclk);
        {io_addr, io_wdata, io_wr} = {a, d, w};
        @(negedge mclk);
        io_wr = 1'b0;
        io_wdata = ~d;
    endtask : iw
endmodule : ucd_host_model
`default_nettype wire

// ---- dv/ucd_config_regs_tb_top.sv ----
// Testbench for the serial ports 3/4 config decode block
`timescale 1ns/100ps
`default_nettype none
module ucd_config_regs_tb_top;
    logic mclk, rst_n, config_state, cfg_wr, cfg_rd, io_wr, cfg_rvalid, v;
    logic [7:0] config_select_index, cfg_wdata, io_wdata, cfg_rdata, d;
    logic [15:0] io_addr;
    logic [4:0] trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    ucd_pkg::ucd_port_s port3, port4;
    ucd_pkg::ucd_fifo_s port4_fifo;
    int n_mismatch = 0, num_checks = 0;
    ucd_config_regs dut (.mclk, .rst_n, .config_state, .config_select_index,
        .cfg_wr, .cfg_rd, .cfg_wdata, .io_wr, .io_addr, .io_wdata,
        .cfg_rdata, .cfg_rvalid, .port3, .port4, .port4_fifo);
    ucd_host_model host (.mclk, .config_state, .cfg_wr, .cfg_rd, .io_wr,
        .config_select_index, .cfg_wdata, .io_wdata, .io_addr, .cfg_rdata,
        .cfg_rvalid);
    task chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Read a register, expecting valid and the given byte
    task rc(input logic [7:0] i, input logic [7:0] e);
        host.cr(1'b1, i, d, v);
        chk({7'h00, v, d}, {8'h01, e});
    endtask : rc
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Watchdog at 4000 cycles, far beyond the sixty or so cycles the tests need
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        rst_n = 1'b0;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        // Reset state: trigger level one byte, both ports off
        chk({7'h00, port4_fifo}, 16'h0001);
        chk({14'h0000, port3.enable, port4.enable}, 16'h0000);
        rc(8'h1b, 8'h00);
        rc(8'h1c, 8'h00);
        host.cw(1'b1, 8'h1b, 8'hff);
        rc(8'h1b, 8'hfe);
        host.cw(1'b1, 8'h1c, 8'h40);
        host.cw(1'b0, 8'h1b, 8'h00);
        rc(8'h1b, 8'hfe);
        // A read outside config state must stay unanswered
        host.cr(1'b0, 8'h1b, d, v);
        chk({15'h0000, v}, 16'h0000);
        host.cw(1'b1, 8'h1a, 8'hff);
        rc(8'h1a, 8'h00);
        rc(8'h1d, 8'h00);
        chk(port3.base_addr, 16'h03f8);
        chk({port4.base_addr[15:1], port4.enable}, 16'h0101);
        // Low bits ignored, high bits must be zero
        host.iw(16'h03fd, 8'h00, 1'b0);
        chk({14'h0000, port3.match, port4.match}, 16'h0002);
        host.iw(16'h07f8, 8'h00, 1'b0);
        chk({15'h0000, port3.match}, 16'h0000);
        host.iw(16'h0107, 8'h00, 1'b0);
        chk({14'h0000, port3.match, port4.match}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            host.iw(16'h0102, {i[1:0], 6'h3f}, 1'b1);
            chk({7'h00, port4_fifo}, {7'h00, 4'hf, trig[i]});
            rc(8'h1a, {i[1:0], 6'h09});
            chk({7'h00, port4_fifo}, {7'h00, 4'h9, trig[i]});
        end
        // Wrong offset, then a disabled port: both ignored
        host.iw(16'h0103, 8'h00, 1'b1);
        host.cw(1'b1, 8'h1c, 8'h00);
        host.iw(16'h0002, 8'h00, 1'b1);
        chk({5'h00, port4.match, port4.enable, port4_fifo}, 16'h012e);
        end_of_test();
    end
endmodule : ucd_config_regs_tb_top
`default_nettype wire
